// ==== shared/scfl_pkg.sv ====
/*
 * Constants, register map and carrier types of the serial capture logger.
 * Assumes a 100 MHz aclk; the top module may override the long counts.
 */
package scfl_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int MS_NS         = 1_000_000;
   localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
   localparam int DATA_BITS     = 8;
   localparam int STOP_BITS     = 1;
   localparam int BUF_DEPTH     = 4096;
   localparam int PTR_W         = 12;
   localparam int SEQ_W         = 14;
   localparam int NAME_W        = 88;

   localparam logic [31:0] BAUD_1200   = 32'h0000_04B0;
   localparam logic [31:0] BAUD_2400   = 32'h0000_0960;
   localparam logic [31:0] BAUD_4800   = 32'h0000_12C0;
   localparam logic [31:0] BAUD_9600   = 32'h0000_2580;
   localparam logic [31:0] BAUD_19200  = 32'h0000_4B00;
   localparam logic [31:0] BAUD_38400  = 32'h0000_9600;
   localparam logic [31:0] BAUD_57600  = 32'h0000_E100;
   localparam logic [31:0] BAUD_115200 = 32'h0001_C200;

   localparam logic [31:0]       RST_BAUD  = BAUD_115200;
   localparam logic [11:0]       RST_FLUSH = 12'h7D0;
   localparam logic [11:0]       MAX_FLUSH = 12'hFFF;
   localparam logic [15:0]       RST_IDLE  = 16'h03E8;
   localparam logic [31:0]       RST_SPLIT = 32'h0098_9680;
   localparam logic [NAME_W-1:0] RST_NAME  = 88'h6461_7461_2020_2020_6461_74;
   localparam logic [SEQ_W-1:0]  SEQ_LAST  = 14'h270F;

   localparam logic [7:0] OFS_BAUD   = 8'h00;
   localparam logic [7:0] OFS_FLUSH  = 8'h04;
   localparam logic [7:0] OFS_IDLE   = 8'h08;
   localparam logic [7:0] OFS_MODE   = 8'h0C;
   localparam logic [7:0] OFS_SPLIT  = 8'h10;
   localparam logic [7:0] OFS_NAME0  = 8'h14;
   localparam logic [7:0] OFS_NAME1  = 8'h18;
   localparam logic [7:0] OFS_EXT    = 8'h1C;
   localparam logic [7:0] OFS_CTRL   = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_SEQ    = 8'h28;
   localparam logic [7:0] OFS_FLEN   = 8'h2C;

   localparam int CTRL_POWER = 0;
   localparam int CTRL_FORGET = 1;
   localparam int ST_SEQ = 0;
   localparam int ST_NUMBERED = 1;
   localparam int ST_HOST = 2;
   localparam int ST_PEND = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_FRAME = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [2:0] PIN_IDLE = 3'h6;

   typedef struct packed {
      logic [31:0]       baud;
      logic [11:0]       flush_cnt;
      logic [15:0]       idle_ms;
      logic              numbered;
      logic [31:0]       split;
      logic [NAME_W-1:0] name;
   } scfl_cfg_t;

   typedef struct packed {
      logic [PTR_W-1:0] start;
      logic [PTR_W-1:0] len;
      logic [SEQ_W-1:0] seq;
      logic             numbered;
   } scfl_flush_t;
endpackage

// ==== verilog/scfl_logger.sv ====
/*
 * Receive path of the serial capture logger: UART receiver, chunk buffer,
 * flush on byte count or idle time, file numbering and an AXI4-Lite slave.
 * Assumes a storage engine that reads a chunk through the read port while
 * flush_valid is high and then raises flush_ready for one cycle.
 */
`timescale 1ns/10ps
// Notes on behaviour
// - Frames are 8N1, LSB first.
// - Only eight listed baud values are supported.
// - Unsupported baud value falls back to 9600.
// - Missing settings start from documented defaults.
// - Settings take effect only at power-up.
// - Bytes are buffered, one write per chunk.
// - Flush byte count is at most 4095.
// - Idle past timeout flushes the buffered bytes.
// - Idle timeout counts whole milliseconds.
// - Single mode uses fixed name; numbered ignores it.
// - Fixed name is 8.3 short form.
// - Numbered files from 0000, request advances one.
// - Each power-up opens next numbered file.
// - Host attach never advances the file.
// - Numbered mode splits files at size limit.
// - Zero size limit disables splitting.
// - Size limit counter is 32 bits.
// - Lost sequence record restarts numbering at zero.
// - Capture stops while the host is attached.
module scfl_logger
   import scfl_pkg::*;
#(
   parameter int MS_CYCLES   = MS_CYC,
   parameter int BAUD_CLK_HZ = CLK_HZ
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output      logic               s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output      logic               s_axi_wready,
   output      logic [1:0]         s_axi_bresp,
   output      logic               s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output      logic               s_axi_arready,
   output      logic [31:0]        s_axi_rdata,
   output      logic [1:0]         s_axi_rresp,
   output      logic               s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               serial_rx,
   input  wire logic               new_file_request_n,
   input  wire logic               usb_host_present,
   output      logic               flush_valid,
   input  wire logic               flush_ready,
   output      scfl_flush_t        flush_desc,
   input  wire logic [PTR_W-1:0]   flush_rd_addr,
   output      logic [7:0]         flush_rd_data,
   output      logic [NAME_W-1:0]  fixed_file_name
);
   typedef enum logic [3:0] {
      RX_IDLE  = 4'h1,
      RX_START = 4'h2,
      RX_DATA  = 4'h4,
      RX_STOP  = 4'h8
   } scfl_rx_t;

   function automatic logic [19:0] bit_cycles(input logic [31:0] baud);
      int hz;
      hz = BAUD_CLK_HZ / 9600;
      unique case (baud)
         BAUD_1200:   hz = BAUD_CLK_HZ / 1200;
         BAUD_2400:   hz = BAUD_CLK_HZ / 2400;
         BAUD_4800:   hz = BAUD_CLK_HZ / 4800;
         BAUD_9600:   hz = BAUD_CLK_HZ / 9600;
         BAUD_19200:  hz = BAUD_CLK_HZ / 19200;
         BAUD_38400:  hz = BAUD_CLK_HZ / 38400;
         BAUD_57600:  hz = BAUD_CLK_HZ / 57600;
         BAUD_115200: hz = BAUD_CLK_HZ / 115200;
         default:     hz = BAUD_CLK_HZ / 9600;
      endcase
      return hz[19:0];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Pin synchronisers: rx, request and host presence, three stages each.
   logic [2:0] s1, s2, s3, pin;
   logic [2:0] next_pin;
   always_comb begin
      next_pin = (pin & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1  <= PIN_IDLE;
         s2  <= PIN_IDLE;
         s3  <= PIN_IDLE;
         pin <= PIN_IDLE;
      end else begin
         s1  <= {serial_rx, new_file_request_n, usb_host_present};
         s2  <= s1;
         s3  <= s2;
         pin <= next_pin;
      end
   end
   logic rx_line, req_n, host;
   logic req_q, next_req_q;
   assign rx_line = pin[2];
   assign req_n   = pin[1];
   assign host    = pin[0];
   assign next_req_q = req_n;

   // Settings store (stands in for the settings file) and active copy.
   scfl_cfg_t   set, next_set, act, next_act;
   logic        pu_req, next_pu_req;
   logic        seq_ok, next_seq_ok;
   logic [1:0]  sticky, next_sticky;
   logic        aw_h, w_h, next_aw_h, next_w_h;
   logic [7:0]  aw_a, next_aw_a;
   logic [31:0] w_d, next_w_d;
   logic [3:0]  w_s, next_w_s;
   logic        bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0]  bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic        wr_en, hit, rhit;
   logic [31:0] rval;
   logic        ovr_set, frm_set;
   logic [SEQ_W-1:0] seq;
   logic [31:0]      file_len;

   assign wr_en = aw_h && w_h && !bvalid;
   assign s_axi_awready = !aw_h && !bvalid;
   assign s_axi_wready  = !w_h && !bvalid;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rresp   = rresp;
   assign s_axi_rdata   = rdata;
   assign fixed_file_name = act.name;

   always_comb begin
      rhit = 1'b1;
      rval = 32'h0000_0000;
      unique case (s_axi_araddr)
         OFS_BAUD:   rval = set.baud;
         OFS_FLUSH:  rval = {20'h0_0000, set.flush_cnt};
         OFS_IDLE:   rval = {16'h0000, set.idle_ms};
         OFS_MODE:   rval = {31'h0000_0000, set.numbered};
         OFS_SPLIT:  rval = set.split;
         OFS_NAME0:  rval = set.name[87:56];
         OFS_NAME1:  rval = set.name[55:24];
         OFS_EXT:    rval = {8'h00, set.name[23:0]};
         OFS_CTRL:   rval = 32'h0000_0000;
         OFS_STATUS: rval = {26'h000_0000, sticky, flush_valid, host, act.numbered, seq_ok};
         OFS_SEQ:    rval = {18'h0_0000, seq};
         OFS_FLEN:   rval = file_len;
         default:    rhit = 1'b0;
      endcase
   end

   always_comb begin
      next_aw_h = aw_h;
      next_w_h = w_h;
      next_aw_a = aw_a;
      next_w_d = w_d;
      next_w_s = w_s;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_set = set;
      next_pu_req = 1'b0;
      next_sticky = sticky;
      hit = 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_h = 1'b1;
         next_aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_h = 1'b1;
         next_w_d = s_axi_wdata;
         next_w_s = s_axi_wstrb;
      end
      if (wr_en) begin
         unique case (aw_a)
            OFS_BAUD:   next_set.baud = merge(set.baud, w_d, w_s);
            OFS_FLUSH:  next_set.flush_cnt = w_s[0] && w_s[1] ? w_d[11:0] : set.flush_cnt;
            OFS_IDLE:   next_set.idle_ms = w_s[0] && w_s[1] ? w_d[15:0] : set.idle_ms;
            OFS_MODE:   next_set.numbered = w_s[0] ? w_d[0] : set.numbered;
            OFS_SPLIT:  next_set.split = merge(set.split, w_d, w_s);
            OFS_NAME0:  next_set.name[87:56] = merge(set.name[87:56], w_d, w_s);
            OFS_NAME1:  next_set.name[55:24] = merge(set.name[55:24], w_d, w_s);
            OFS_EXT:    next_set.name[23:0] = 24'(merge({8'h00, set.name[23:0]}, w_d, w_s));
            OFS_CTRL:   next_pu_req = w_s[0] && w_d[CTRL_POWER];
            OFS_STATUS: next_sticky = sticky & ~({2{w_s[0]}} & w_d[ST_FRAME:ST_OVERRUN]);
            OFS_SEQ, OFS_FLEN: hit = 1'b1;
            default:    hit = 1'b0;
         endcase
         next_aw_h = 1'b0;
         next_w_h = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // Hardware events win over a clear in the same cycle.
      next_sticky = next_sticky | {frm_set, ovr_set};
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = rval;
         next_rresp = rhit ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_h <= 1'b0;
         w_h <= 1'b0;
         aw_a <= 8'h00;
         w_d <= 32'h0000_0000;
         w_s <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
         set <= '{RST_BAUD, RST_FLUSH, RST_IDLE, 1'b0, RST_SPLIT, RST_NAME};
         sticky <= 2'h0;
      end else begin
         aw_h <= next_aw_h;
         w_h <= next_w_h;
         aw_a <= next_aw_a;
         w_d <= next_w_d;
         w_s <= next_w_s;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         set <= next_set;
         sticky <= next_sticky;
      end
   end

   // UART receiver, 8N1, sampled mid-bit.
   scfl_rx_t    rx_st, next_rx_st;
   logic [19:0] bcyc, next_bcyc, bcnt, next_bcnt;
   logic [2:0]  bidx, next_bidx;
   logic [7:0]  shreg, next_shreg;
   logic        byte_ok, next_byte_ok;
   logic        capture;
   assign capture = !host;

   always_comb begin
      next_rx_st = rx_st;
      next_bcnt = bcnt - 20'h0_0001;
      next_bidx = bidx;
      next_shreg = shreg;
      next_byte_ok = 1'b0;
      next_bcyc = bit_cycles(act.baud);
      frm_set = 1'b0;
      unique case (rx_st)
         RX_IDLE: begin
            next_bcnt = bcyc >> 1;
            if (!rx_line && capture) begin
               next_rx_st = RX_START;
            end
         end
         RX_START: begin
            if (bcnt == 20'h0_0000) begin
               next_bcnt = bcyc - 20'h0_0001;
               next_bidx = 3'h0;
               next_rx_st = rx_line ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (bcnt == 20'h0_0000) begin
               next_bcnt = bcyc - 20'h0_0001;
               next_shreg = {rx_line, shreg[7:1]};
               next_bidx = bidx + 3'h1;
               if (bidx == 3'(DATA_BITS - 1)) begin
                  next_rx_st = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (bcnt == 20'h0_0000) begin
               next_rx_st = RX_IDLE;
               next_byte_ok = rx_line && capture;
               frm_set = !rx_line;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_st <= RX_IDLE;
         bcyc <= 20'h0_0001;
         bcnt <= 20'h0_0000;
         bidx <= 3'h0;
         shreg <= 8'h00;
         byte_ok <= 1'b0;
      end else begin
         rx_st <= next_rx_st;
         bcyc <= next_bcyc;
         bcnt <= next_bcnt;
         bidx <= next_bidx;
         shreg <= next_shreg;
         byte_ok <= next_byte_ok;
      end
   end

   // Chunk buffer, flush triggers and file bookkeeping.
   logic [7:0]       mem [BUF_DEPTH];
   logic [PTR_W-1:0] wptr, next_wptr, cstart, next_cstart, ccnt, next_ccnt;
   logic [16:0]      msdiv, next_msdiv;
   logic [15:0]      idle, next_idle;
   logic             pend, next_pend;
   scfl_flush_t      desc, next_desc;
   logic [SEQ_W-1:0] next_seq;
   logic [31:0]      next_file_len, grown;
   logic             acc, tick, advance, room;
   logic [PTR_W:0]   used;

   assign used = {1'b0, ccnt} + (pend ? {1'b0, desc.len} : 13'h0000);
   assign room = (ccnt != MAX_FLUSH) && (used < 13'(BUF_DEPTH));
   assign acc = byte_ok && room;
   assign ovr_set = byte_ok && !room;
   assign tick = (msdiv == 17'(MS_CYCLES - 1));
   assign flush_valid = pend;
   assign flush_desc = desc;
   assign grown = file_len + {20'h0_0000, desc.len};

   always_comb begin
      next_act = act;
      next_seq = seq;
      next_seq_ok = seq_ok;
      next_file_len = file_len;
      next_wptr = wptr + PTR_W'(acc);
      next_cstart = cstart;
      next_ccnt = ccnt + PTR_W'(acc);
      next_pend = pend;
      next_desc = desc;
      next_msdiv = tick ? 17'h0_0000 : msdiv + 17'h0_0001;
      next_idle = (tick && idle != 16'hFFFF) ? idle + 16'h0001 : idle;
      advance = 1'b0;
      if (acc) begin
         next_msdiv = 17'h0_0000;
         next_idle = 16'h0000;
      end
      if (!pend && ccnt != 12'h000 &&
          (ccnt >= act.flush_cnt || ccnt == MAX_FLUSH ||
           (!acc && idle >= act.idle_ms))) begin
         next_pend = 1'b1;
         next_desc = '{cstart, ccnt, seq, act.numbered};
         next_cstart = wptr;
         next_ccnt = PTR_W'(acc);
      end
      if (pend && flush_ready) begin
         next_pend = 1'b0;
         next_file_len = grown;
         if (act.numbered && act.split != 32'h0000_0000 && grown >= act.split) begin
            advance = 1'b1;
         end
      end
      if (act.numbered && req_q && !req_n) begin
         advance = 1'b1;
      end
      if (advance) begin
         next_seq = (seq == SEQ_LAST) ? '0 : seq + 14'h0001;
         next_file_len = 32'h0000_0000;
      end
      if (wr_en && aw_a == OFS_CTRL && w_s[0] && w_d[CTRL_FORGET]) begin
         next_seq_ok = 1'b0;
      end
      if (pu_req) begin
         next_act = set;
         next_file_len = 32'h0000_0000;
         if (set.numbered) begin
            next_seq_ok = 1'b1;
            next_seq = !seq_ok ? '0 : (seq == SEQ_LAST) ? '0 : seq + 14'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (acc) begin
         mem[wptr] <= shreg;
      end
      flush_rd_data <= mem[flush_rd_addr];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act <= '{RST_BAUD, RST_FLUSH, RST_IDLE, 1'b0, RST_SPLIT, RST_NAME};
         pu_req <= 1'b1;
         seq_ok <= 1'b0;
         seq <= '0;
         file_len <= 32'h0000_0000;
         req_q <= 1'b1;
         wptr <= '0;
         cstart <= '0;
         ccnt <= '0;
         msdiv <= 17'h0_0000;
         idle <= 16'h0000;
         pend <= 1'b0;
         desc <= '0;
      end else begin
         act <= next_act;
         pu_req <= next_pu_req;
         seq_ok <= next_seq_ok;
         seq <= next_seq;
         file_len <= next_file_len;
         req_q <= next_req_q;
         wptr <= next_wptr;
         cstart <= next_cstart;
         ccnt <= next_ccnt;
         msdiv <= next_msdiv;
         idle <= next_idle;
         pend <= next_pend;
         desc <= next_desc;
      end
   end
endmodule // scfl_logger

// ==== verif/scfl_logger_properties.sv ====
/* Checker of the logger's bus answers and chunk handshake.
   Assumes binding to scfl_logger and sight of its ports only. */
`timescale 1ns/10ps
module scfl_logger_properties
   import scfl_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        flush_valid,
   input wire logic        flush_ready,
   input wire scfl_flush_t flush_desc
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence chunk_wait;
      flush_valid && !flush_ready;
   endsequence
   sequence chunk_take;
      flush_valid && flush_ready;
   endsequence
   chunk_hold_a: assert property (chunk_wait |=> flush_valid && $stable(flush_desc))
      else $error("chunk descriptor moved before acceptance");
   chunk_drop_a: assert property (chunk_take |=> !flush_valid)
      else $error("chunk still offered after acceptance");
   chunk_len_a: assert property (flush_valid |-> flush_desc.len != 12'h000)
      else $error("empty chunk offered");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");
   chunk_take_c: cover property (chunk_take);
endmodule // scfl_logger_properties

bind scfl_logger scfl_logger_properties u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .flush_valid(flush_valid),
   .flush_ready(flush_ready), .flush_desc(flush_desc));

// ==== verif/scfl_app_model.sv ====
/* Behavioural application device: sends serial frames and file requests.
   Assumes its tasks are called right after a rising edge of aclk. */
`timescale 1ns/10ps
module scfl_app_model (
   output      logic serial_rx,
   output      logic new_file_request_n,
   input  wire logic aclk
);
   initial begin
      serial_rx = 1'b1;
      new_file_request_n = 1'b1;
   end
   task automatic send_byte(input logic [7:0] b, input int bc);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++) begin
         serial_rx <= fr[k];
         repeat (bc) @(posedge aclk);
      end
   endtask
   // The request is only made while the line is idle, and held well past the minimum.
   task automatic request(input int cyc);
      new_file_request_n <= 1'b0;
      repeat (cyc) @(posedge aclk);
      new_file_request_n <= 1'b1;
      @(posedge aclk);
   endtask
endmodule // scfl_app_model

// ==== verif/tb_scfl_logger.sv ====
/* Self-checking bench of the logger: AXI4-Lite tasks, storage drain, serial traffic.
   Assumes a 1 ms tick of 100 cycles and 10 cycles per bit at 115200. */
`timescale 1ns/10ps
module tb_scfl_logger
   import scfl_pkg::*;
;
   localparam logic [7:0]  RA [5] = '{OFS_BAUD, OFS_FLUSH, OFS_IDLE, OFS_MODE, OFS_SPLIT};
   localparam logic [31:0] RV [5] = '{RST_BAUD, 32'(RST_FLUSH), 32'(RST_IDLE), 32'h0, RST_SPLIT};
   localparam logic [31:0] BT [9] = '{BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200,
                                      BAUD_38400, BAUD_57600, 32'h0000_04D2, BAUD_115200};
   logic              aclk = 0;
   logic              aresetn = 0;
   logic [7:0]        awaddr = 0;
   logic [7:0]        araddr = 0;
   logic [31:0]       wdata = 0;
   logic              awvalid = 0, wvalid = 0, arvalid = 0, usb = 0, flush_ready = 0;
   logic              bready = 0, rready = 0;
   logic [3:0]        strb = 4'hF;
   logic              awready, wready, bvalid, arready, rvalid, flush_valid;
   logic [1:0]        bresp, rresp, rs;
   logic [31:0]       rdata, rd;
   scfl_flush_t       flush_desc;
   logic [PTR_W-1:0]  rd_addr = 0;
   logic [7:0]        rd_data;
   logic [NAME_W-1:0] name;
   logic              serial_rx, req_n;
   logic [SEQ_W-1:0]  exp_seq;
   logic [7:0]        sent_q [$];
   int                failures = 0;
   int                check_count = 0;
   always #5 aclk = ~aclk;
   scfl_logger #(.MS_CYCLES(100), .BAUD_CLK_HZ(1152000)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .serial_rx(serial_rx), .new_file_request_n(req_n), .usb_host_present(usb),
      .flush_valid(flush_valid), .flush_ready(flush_ready), .flush_desc(flush_desc),
      .flush_rd_addr(rd_addr), .flush_rd_data(rd_data), .fixed_file_name(name));
   scfl_app_model u_app (.serial_rx(serial_rx), .new_file_request_n(req_n), .aclk(aclk));
   task automatic final_report();
      if (failures == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic timeout();
      failures++;
      final_report();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Ready lines rise with the valids and drop after the response, so readies, valids and payloads all move here.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      if (n >= 200) timeout();
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      if (n >= 200) timeout();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic tx(input logic [7:0] b, input int bc);
      sent_q.push_back(b);
      u_app.send_byte(b, bc);
   endtask
   task automatic pcycle();
      axi_write(OFS_CTRL, 32'h0000_0001);
   endtask
   // Storage side: reads the chunk byte by byte, then accepts it.
   task automatic drain(input int len);
      int n;
      logic [PTR_W-1:0] st;
      n = 0;
      while (flush_valid !== 1'b1 && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 20000) timeout();
      check(32'(flush_desc.len), 32'(len));
      check(32'(flush_desc.seq), 32'(exp_seq));
      check(32'(flush_desc.numbered), 32'h0000_0001);
      st = flush_desc.start;
      for (n = 0; n < len; n++) begin
         rd_addr <= st + PTR_W'(n);
         repeat (2) @(posedge aclk);
         check(32'(rd_data), 32'(sent_q.pop_front()));
      end
      flush_ready <= 1'b1;
      @(posedge aclk);
      flush_ready <= 1'b0;
      @(posedge aclk);
   endtask
   initial begin
      repeat (90000) @(posedge aclk);
      timeout();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      strb <= 4'h0;
      axi_write(OFS_BAUD, 32'h0000_0000);
      strb <= 4'hF;
      for (int i = 0; i < 5; i++) begin
         axi_read(RA[i], rd, rs);
         check(rd, RV[i]);
      end
      check(name[31:0], RST_NAME[31:0]);
      check(name[87:56], RST_NAME[87:56]);
      axi_read(8'h3C, rd, rs);
      check(rd, 32'h0000_0000);
      check(32'(rs), 32'(RESP_DECERR));
      axi_write(8'h3C, 32'h0000_0000);
      check(32'(bresp), 32'(RESP_DECERR));
      axi_write(OFS_FLUSH, 32'h0000_0003);
      axi_write(OFS_IDLE, 32'h0000_0002);
      axi_write(OFS_MODE, 32'h0000_0001);
      axi_write(OFS_SPLIT, 32'h0000_0005);
      for (int i = 0; i < 3; i++) tx(8'hA5 ^ 8'(i * 51), 10);
      repeat (20) @(posedge aclk);
      check(32'(flush_valid), 32'h0000_0000);
      pcycle();
      exp_seq = 0;
      drain(3);
      for (int i = 0; i < 3; i++) tx(8'h0F + 8'(i), 10);
      drain(3);
      exp_seq = 1;
      axi_read(OFS_SEQ, rd, rs);
      check(rd, 32'(exp_seq));
      axi_read(OFS_FLEN, rd, rs);
      check(rd, 32'h0000_0000);
      tx(8'hC3, 10);
      repeat (150) @(posedge aclk);
      check(32'(flush_valid), 32'h0000_0000);
      drain(1);
      u_app.request(5000);
      exp_seq = 2;
      repeat (10) @(posedge aclk);
      axi_read(OFS_SEQ, rd, rs);
      check(rd, 32'(exp_seq));
      usb <= 1'b1;
      repeat (10) @(posedge aclk);
      u_app.send_byte(8'hEE, 10);
      repeat (400) @(posedge aclk);
      check(32'(flush_valid), 32'h0000_0000);
      axi_read(OFS_SEQ, rd, rs);
      check(rd, 32'(exp_seq));
      usb <= 1'b0;
      repeat (10) @(posedge aclk);
      axi_write(OFS_FLUSH, 32'h0000_0001);
      axi_write(OFS_SPLIT, 32'h0000_0000);
      // The unlisted rate must run at the 9600 bit time.
      for (int i = 0; i < 9; i++) begin
         axi_write(OFS_BAUD, BT[i]);
         pcycle();
         exp_seq++;
         tx(8'(i * 17 + 3), (i == 7) ? 1152000 / 9600 : 1152000 / int'(BT[i]));
         drain(1);
      end
      for (int i = 0; i < 6; i++) begin
         tx(8'h40 + 8'(i), 10);
         drain(1);
      end
      axi_read(OFS_SEQ, rd, rs);
      check(rd, 32'(exp_seq));
      axi_write(OFS_CTRL, 32'h0000_0002);
      pcycle();
      axi_read(OFS_SEQ, rd, rs);
      check(rd, 32'h0000_0000);
      final_report();
   end
endmodule // tb_scfl_logger
